// [flag_pkg.sv]
package flag_pkg;
    // ------------------------------------------------------------------
    // Register map (APB byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_FLAG_WORD = 8'h00;
    localparam logic [7:0] ADDR_CONTROL = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_DECODE_A = 8'h0C;
    localparam logic [7:0] ADDR_DECODE_B = 8'h10;
    localparam logic [7:0] ADDR_ID = 8'h14;
    // Identification value; arbitrary
    localparam logic [31:0] ID_VALUE = 32'h0000_5A01;

    // ------------------------------------------------------------------
    // Flag word layout
    // ------------------------------------------------------------------
    localparam int FLAG_W = 24;
    localparam int HALF_W = 12;
    localparam int BIT_OUT_A = 0;
    localparam int BIT_OUT_B = 1;
    // Older layout
    localparam int OLD_FREQ_LO = 8;
    localparam int OLD_ACQ = 7;
    localparam int OLD_PZERO = 6;
    localparam int OLD_DIG_LO = 2;
    localparam int OLD_TXG = 12;
    localparam int OLD_TXPH_LO = 16;
    // Newer layout
    localparam int NEW_ACQ = 10;
    localparam int NEW_PZERO = 9;
    localparam int NEW_TXG = 15;
    localparam int NEW_DIG_LO = 2;
    localparam int NEW_AMP_LO = 4;
    localparam int NEW_SHAPE_LO = 6;
    localparam int NEW_FREQ_HI = 11;
    localparam int NEW_FREQ_LO = 13;
    localparam int NEW_TXPH_LO = 16;
    // Both layouts
    localparam int SIN_PH_LO = 22;
    localparam int COS_PH_LO = 20;

    // ------------------------------------------------------------------
    // Control register bits
    // ------------------------------------------------------------------
    localparam int CTL_NEW_LAYOUT = 0;
    localparam int CTL_SW_START = 1;
    localparam int CTL_RESUME = 2;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_MHZ = 50;
    localparam int RESUME_MIN_CYC = 8;
    localparam int SYNC_STAGES = 3;
endpackage : flag_pkg

// [pin_sync.sv]
`timescale 1ns/100ps
module pin_sync
    import flag_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pin_n,
    output logic level_n
);
    logic [SYNC_STAGES-1:0] stage_reg;
    logic [SYNC_STAGES-1:0] stage_next;
    logic level_reg;
    logic level_next;

    // Shift chain; a change counts when stages two and three agree
    always_comb begin
        stage_next = {stage_reg[SYNC_STAGES-2:0], pin_n};
        level_next = level_reg;
        if (stage_reg[1] == stage_reg[2]) begin
            level_next = stage_reg[2];
        end
    end

    // Rest level is high, the inactive state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage_reg <= '1;
            level_reg <= 1'b1;
        end else begin
            stage_reg <= stage_next;
            level_reg <= level_next;
        end
    end

    assign level_n = level_reg;
endmodule : pin_sync

// [flag_decode.sv]
`timescale 1ns/100ps
module flag_decode
    import flag_pkg::*;
(
    input wire logic [FLAG_W-1:0] flags,
    input wire logic new_layout,
    output logic [3:0] freq_sel,
    output logic [1:0] sin_sel,
    output logic [1:0] cos_sel,
    output logic [3:0] tx_phase_sel,
    output logic [3:0] dig_out,
    output logic [1:0] amp_sel,
    output logic [2:0] shape_sel,
    output logic acq_line,
    output logic pzero_line,
    output logic txg_line
);
    // Field split by firmware layout
    always_comb begin
        sin_sel = flags[SIN_PH_LO +: 2];
        cos_sel = flags[COS_PH_LO +: 2];
        if (new_layout) begin
            freq_sel = {2'h0, flags[NEW_FREQ_HI], flags[NEW_FREQ_LO]};
            tx_phase_sel = {1'b0, flags[NEW_TXPH_LO +: 3]};
            dig_out = {2'h0, flags[NEW_DIG_LO +: 2]};
            amp_sel = flags[NEW_AMP_LO +: 2];
            shape_sel = flags[NEW_SHAPE_LO +: 3];
            acq_line = flags[NEW_ACQ];
            pzero_line = flags[NEW_PZERO];
            txg_line = flags[NEW_TXG];
        end else begin
            freq_sel = flags[OLD_FREQ_LO +: 4];
            tx_phase_sel = flags[OLD_TXPH_LO +: 4];
            dig_out = flags[OLD_DIG_LO +: 4];
            amp_sel = 2'h0;
            shape_sel = 3'h0;
            acq_line = flags[OLD_ACQ];
            pzero_line = flags[OLD_PZERO];
            txg_line = flags[OLD_TXG];
        end
    end
endmodule : flag_decode

// [flag_pins.sv]
// Function
// - All 24 flag bits appear on two 12-bit headers, low and high.
// - Bits used internally still drive the header pins.
// - Flag bits 0 and 1 drive general outputs a and b.
// - Older layout: freq 8-11, launch 7, zero 6, digital 2-5, gate 12.
// - Newer layout: launch 10, zero 9, gate 15, digital 2-3, amp, shape.
// - Bits 22-23 sine phase, 20-21 cosine phase, upper teens transmit.
// - Low hardware start input acts like a software start.
// - Low program clear input resets the pulse program.
// - Undriven start and clear inputs rest high and inactive.
// - A scan starts only on a rising acquire launch edge.
// - Phase zero line holds every channel at time-zero phase.
// - Start pin acts five cycles after it falls, software start after one; resume waits at least eight.
// - Gate low forces the transmit output to zero.
`timescale 1ns/100ps
module flag_pins
    import flag_pkg::*;
#(
    parameter int RESUME_CYC = RESUME_MIN_CYC
)(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [FLAG_W-1:0] flag_word,
    input wire logic flag_valid,
    input wire logic [13:0] tx_sample,
    input wire logic scan_done,
    input wire logic hardware_start_in_n,
    input wire logic external_program_clear_n,
    output logic [HALF_W-1:0] low_flag_outputs,
    output logic [HALF_W-1:0] high_flag_outputs,
    output logic general_out_a,
    output logic general_out_b,
    output logic [3:0] freq_select,
    output logic [1:0] sin_phase_select,
    output logic [1:0] cos_phase_select,
    output logic [3:0] tx_phase_select,
    output logic [1:0] amp_select,
    output logic [2:0] shape_select,
    output logic dds_phase_zero,
    output logic scan_start,
    output logic scan_busy,
    output logic [13:0] tx_out,
    output logic program_start,
    output logic program_clear
);
    // Elaboration check: the wait counter is eight bits wide
    if (RESUME_CYC < RESUME_MIN_CYC || RESUME_CYC > 255) begin : g_bad_resume
        $error("RESUME_CYC out of range");
    end

    // ------------------------------------------------------------------
    // Pin synchronisers and field decode
    // ------------------------------------------------------------------
    logic start_n_sync;
    logic clear_n_sync;
    logic [3:0] d_freq;
    logic [1:0] d_sin;
    logic [1:0] d_cos;
    logic [3:0] d_txph;
    logic [3:0] d_dig;
    logic [1:0] d_amp;
    logic [2:0] d_shape;
    logic d_acq;
    logic d_pzero;
    logic d_txg;
    logic new_layout_reg;
    logic new_layout_next;

    pin_sync start_sync_u (
        .pclk(pclk),
        .presetn(presetn),
        .pin_n(hardware_start_in_n),
        .level_n(start_n_sync)
    );

    pin_sync clear_sync_u (
        .pclk(pclk),
        .presetn(presetn),
        .pin_n(external_program_clear_n),
        .level_n(clear_n_sync)
    );

    flag_decode decode_u (
        .flags(flag_word),
        .new_layout(new_layout_reg),
        .freq_sel(d_freq),
        .sin_sel(d_sin),
        .cos_sel(d_cos),
        .tx_phase_sel(d_txph),
        .dig_out(d_dig),
        .amp_sel(d_amp),
        .shape_sel(d_shape),
        .acq_line(d_acq),
        .pzero_line(d_pzero),
        .txg_line(d_txg)
    );

    // ------------------------------------------------------------------
    // Flag outputs
    // ------------------------------------------------------------------
    logic [FLAG_W-1:0] word_reg;
    logic [FLAG_W-1:0] word_next;
    logic acq_prev_reg;
    logic acq_prev_next;
    logic scan_start_next;
    logic scan_busy_next;
    logic txg_reg;
    logic txg_next;
    logic [13:0] tx_out_next;

    // Latch the current instruction's flags and its decoded lines
    always_comb begin
        word_next = flag_valid ? flag_word : word_reg;
        acq_prev_next = d_acq;
        scan_start_next = d_acq && !acq_prev_reg;
        scan_busy_next = scan_busy;
        if (scan_start_next) begin
            scan_busy_next = 1'b1;
        end else if (scan_done) begin
            scan_busy_next = 1'b0;
        end
        txg_next = d_txg;
        tx_out_next = d_txg ? tx_sample : 14'h0000;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            word_reg <= '0;
            low_flag_outputs <= '0;
            high_flag_outputs <= '0;
            general_out_a <= 1'b0;
            general_out_b <= 1'b0;
            freq_select <= 4'h0;
            sin_phase_select <= 2'h0;
            cos_phase_select <= 2'h0;
            tx_phase_select <= 4'h0;
            amp_select <= 2'h0;
            shape_select <= 3'h0;
            dds_phase_zero <= 1'b0;
            acq_prev_reg <= 1'b0;
            scan_start <= 1'b0;
            scan_busy <= 1'b0;
            txg_reg <= 1'b0;
            tx_out <= 14'h0000;
        end else begin
            word_reg <= word_next;
            low_flag_outputs <= flag_word[HALF_W-1:0];
            high_flag_outputs <= flag_word[FLAG_W-1:HALF_W];
            general_out_a <= flag_word[BIT_OUT_A];
            general_out_b <= flag_word[BIT_OUT_B];
            freq_select <= d_freq;
            sin_phase_select <= d_sin;
            cos_phase_select <= d_cos;
            tx_phase_select <= d_txph;
            amp_select <= d_amp;
            shape_select <= d_shape;
            dds_phase_zero <= d_pzero;
            acq_prev_reg <= acq_prev_next;
            scan_start <= scan_start_next;
            scan_busy <= scan_busy_next;
            txg_reg <= txg_next;
            tx_out <= tx_out_next;
        end
    end

    // ------------------------------------------------------------------
    // Trigger and clear
    // ------------------------------------------------------------------
    logic start_prev_reg;
    logic start_prev_next;
    logic sw_start_reg;
    logic sw_start_next;
    logic resume_reg;
    logic resume_next;
    logic [7:0] wait_cnt_reg;
    logic [7:0] wait_cnt_next;
    logic program_start_next;
    logic start_event;

    // Start pulse: prompt when starting, delayed when resuming from wait
    always_comb begin
        start_prev_next = start_n_sync;
        start_event = (!start_n_sync && start_prev_reg) || sw_start_reg;
        wait_cnt_next = wait_cnt_reg;
        program_start_next = 1'b0;
        if (!clear_n_sync) begin
            wait_cnt_next = 8'h00;
        end else if (wait_cnt_reg != 8'h00) begin
            wait_cnt_next = wait_cnt_reg - 8'h01;
            program_start_next = (wait_cnt_reg == 8'h01);
        end else if (start_event) begin
            if (resume_reg) begin
                wait_cnt_next = 8'(RESUME_CYC - 1);
            end else begin
                program_start_next = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_prev_reg <= 1'b1;
            wait_cnt_reg <= 8'h00;
            program_start <= 1'b0;
            program_clear <= 1'b0;
        end else begin
            start_prev_reg <= start_prev_next;
            wait_cnt_reg <= wait_cnt_next;
            program_start <= program_start_next;
            program_clear <= !clear_n_sync;
        end
    end

    // ------------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------------
    logic [31:0] prdata_next;
    logic pslverr_next;
    logic pready_next;
    logic wr_en;
    logic setup;

    // Zero-wait decode: answer raised in the access cycle's setup edge
    always_comb begin
        setup = psel && !penable;
        wr_en = psel && penable && pready && pwrite;
        new_layout_next = new_layout_reg;
        resume_next = resume_reg;
        sw_start_next = 1'b0;
        pready_next = setup;
        prdata_next = 32'h0000_0000;
        pslverr_next = 1'b0;
        if (wr_en && paddr == ADDR_CONTROL) begin
            new_layout_next = pwdata[CTL_NEW_LAYOUT];
            sw_start_next = pwdata[CTL_SW_START];
            resume_next = pwdata[CTL_RESUME];
        end
        if (setup) begin
            unique case (paddr)
                ADDR_FLAG_WORD: prdata_next = {8'h00, word_reg};
                ADDR_CONTROL: prdata_next = {29'h0, resume_reg, 1'b0,
                    new_layout_reg};
                ADDR_STATUS: prdata_next = {26'h0, txg_reg, scan_busy,
                    dds_phase_zero, !clear_n_sync, !start_n_sync,
                    wait_cnt_reg != 8'h00};
                ADDR_DECODE_A: prdata_next = {20'h00000, freq_select,
                    tx_phase_select, cos_phase_select, sin_phase_select};
                ADDR_DECODE_B: prdata_next = {23'h0, d_dig, shape_select,
                    amp_select};
                ADDR_ID: prdata_next = ID_VALUE;
                default: pslverr_next = 1'b1;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            new_layout_reg <= 1'b0;
            resume_reg <= 1'b0;
            sw_start_reg <= 1'b0;
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            new_layout_reg <= new_layout_next;
            resume_reg <= resume_next;
            sw_start_reg <= sw_start_next;
            pready <= pready_next;
            prdata <= prdata_next;
            pslverr <= pslverr_next;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    sequence launch_rise_s;
        !$past(d_acq) && d_acq;
    endsequence

    header_low_a: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 low_flag_outputs == $past(flag_word[HALF_W-1:0]))
        else $error("low header mismatch");
    header_high_a: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 high_flag_outputs == $past(flag_word[FLAG_W-1:HALF_W]))
        else $error("high header mismatch");
    general_out_a_a: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 general_out_a == $past(flag_word[BIT_OUT_A]))
        else $error("general output a mismatch");
    general_out_b_a: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 general_out_b == $past(flag_word[BIT_OUT_B]))
        else $error("general output b mismatch");
    old_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        !new_layout_reg |=> dds_phase_zero == $past(flag_word[OLD_PZERO]))
        else $error("old layout phase zero mismatch");
    new_launch_a: assert property (@(posedge pclk) disable iff (!presetn)
        new_layout_reg && flag_word[NEW_ACQ] && !acq_prev_reg
        |=> scan_start)
        else $error("new layout launch missed");
    sin_select_a: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 sin_phase_select == $past(flag_word[SIN_PH_LO +: 2]))
        else $error("sine select mismatch");
    clear_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
        !external_program_clear_n [*3] |-> ##[1:3] program_clear)
        else $error("clear not applied");
    start_prompt_a: assert property (@(posedge pclk) disable iff (!presetn)
        wait_cnt_reg == 8'h00 && !resume_reg && clear_n_sync && sw_start_reg
        |=> program_start)
        else $error("start not prompt");
    resume_late_a: assert property (@(posedge pclk) disable iff (!presetn)
        wait_cnt_reg == 8'h00 && resume_reg && clear_n_sync && start_event
        |=> !program_start [*7])
        else $error("resume too early");
    scan_edge_a: assert property (@(posedge pclk) disable iff (!presetn)
        scan_start |-> $past(d_acq) && !$past(acq_prev_reg))
        else $error("scan started without edge");
    scan_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        launch_rise_s ##1 !scan_done |=> scan_busy)
        else $error("scan dropped early");
    tx_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        !txg_reg |-> tx_out == 14'h0000)
        else $error("transmit not zeroed");
endmodule : flag_pins

// [lab_equipment.sv]
`timescale 1ns/100ps
module lab_equipment (
    input wire logic start_req,
    input wire logic clear_req,
    output logic hardware_start_in_n,
    output logic external_program_clear_n
);
    // -------------------------------------------------------------
    // Pin drivers
    // -------------------------------------------------------------
    // Pull-ups hold both pins high unless a request pulls them low
    assign hardware_start_in_n = start_req ? 1'b0 : 1'b1;
    assign external_program_clear_n = clear_req ? 1'b0 : 1'b1;
endmodule : lab_equipment

// [flag_word_pins_and_hardware_start_in_tb_top.sv]
`timescale 1ns/100ps
module flag_word_pins_and_hardware_start_in_tb_top;
    import flag_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic pready, pslverr, rerr, nl, prev_acq, busy_exp;
    logic [23:0] flag_word = 24'h0;
    logic flag_valid = 1'b0, scan_done = 1'b0;
    logic [13:0] tx_sample = 14'h0, tx_out;
    logic start_req = 1'b0, clear_req = 1'b0, start_n, clear_n;
    logic [11:0] low_flag_outputs, high_flag_outputs;
    logic general_out_a, general_out_b, dds_phase_zero, scan_start;
    logic scan_busy, program_start, program_clear;
    logic [3:0] freq_select, tx_phase_select;
    logic [1:0] sin_phase_select, cos_phase_select, amp_select;
    logic [2:0] shape_select;
    logic [23:0] corner [4] = '{24'hFFFFFF, 24'h000000, 24'hAAAAAA, 24'h555555};
    int err_total = 0, tests_run = 0, seed = 30637;

    // -------------------------------------------------------------
    // Clock, design and far side
    // -------------------------------------------------------------
    // 50 MHz board timebase
    always #10 pclk = ~pclk;

    flag_pins u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .flag_word(flag_word), .flag_valid(flag_valid),
        .tx_sample(tx_sample), .scan_done(scan_done),
        .hardware_start_in_n(start_n), .external_program_clear_n(clear_n),
        .low_flag_outputs(low_flag_outputs),
        .high_flag_outputs(high_flag_outputs),
        .general_out_a(general_out_a), .general_out_b(general_out_b),
        .freq_select(freq_select), .sin_phase_select(sin_phase_select),
        .cos_phase_select(cos_phase_select),
        .tx_phase_select(tx_phase_select), .amp_select(amp_select),
        .shape_select(shape_select), .dds_phase_zero(dds_phase_zero),
        .scan_start(scan_start), .scan_busy(scan_busy), .tx_out(tx_out),
        .program_start(program_start), .program_clear(program_clear));

    lab_equipment u_lab (.start_req(start_req), .clear_req(clear_req),
        .hardware_start_in_n(start_n), .external_program_clear_n(clear_n));

    // -------------------------------------------------------------
    // Checking and bus tasks
    // -------------------------------------------------------------
    task automatic close_out();
        $display("Checks %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : close_out

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // One APB transfer, entered just after a rising edge
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            err_total++;
            close_out();
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    // Apply one flag word and check the flag-driven outputs; amp and shape only in the newer layout
    task automatic step(input logic [23:0] f, input logic [13:0] s);
        logic acq, pz, tg;
        flag_word <= f;
        tx_sample <= s;
        flag_valid <= 1'b1;
        @(posedge pclk);
        @(negedge pclk);
        acq = nl ? f[NEW_ACQ] : f[OLD_ACQ];
        pz = nl ? f[NEW_PZERO] : f[OLD_PZERO];
        tg = nl ? f[NEW_TXG] : f[OLD_TXG];
        // Busy is raised by the same edge that launches the scan
        busy_exp = busy_exp | (acq & ~prev_acq);
        chk("low header", f[11:0], low_flag_outputs);
        chk("high header", f[23:12], high_flag_outputs);
        chk("out a", f[BIT_OUT_A], general_out_a);
        chk("out b", f[BIT_OUT_B], general_out_b);
        chk("sin sel", f[23:22], sin_phase_select);
        chk("cos sel", f[21:20], cos_phase_select);
        chk("phase zero", pz, dds_phase_zero);
        chk("tx out", tg ? s : 14'h0, tx_out);
        chk("scan start", acq & ~prev_acq, scan_start);
        chk("scan busy", busy_exp, scan_busy);
        if (nl) begin
            chk("amp sel", f[5:4], amp_select);
            chk("shape sel", f[8:6], shape_select);
            chk("tx phase", {1'b0, f[18:16]}, tx_phase_select);
            chk("freq sel", {2'b00, f[11], f[13]}, freq_select);
        end else begin
            chk("freq sel", f[11:8], freq_select);
            chk("tx phase", f[19:16], tx_phase_select);
        end
        prev_acq = acq;
        @(posedge pclk);
    endtask : step

    // Pull the start pin low and time the program start pulse
    task automatic hw_start(input int lo, input int hi, input int want);
        int n, hits, at;
        n = 0;
        hits = 0;
        at = 0;
        start_req <= 1'b1;
        repeat (hi + 4) begin
            @(negedge pclk);
            n++;
            if (program_start === 1'b1) begin
                hits++;
                at = n;
            end
        end
        @(posedge pclk);
        start_req <= 1'b0;
        repeat (4) @(posedge pclk);
        chk("start pulses", want, hits);
        if (want > 0) begin
            chk("start delay", 1, at >= lo && at <= hi);
        end
    endtask : hw_start

    // Bounded wait for the program clear level
    task automatic wait_clear(input logic v);
        int n;
        n = 0;
        while (program_clear !== v && n < 10) begin
            @(negedge pclk);
            n++;
        end
        chk("program clear", v, program_clear);
        @(posedge pclk);
    endtask : wait_clear

    // -------------------------------------------------------------
    // Main sequence
    // -------------------------------------------------------------
    // Reset, registers, both layouts, scan end, pins
    initial begin
        nl = 1'b0;
        prev_acq = 1'b0;
        busy_exp = 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, ADDR_ID, 32'h0);
        chk("id", ID_VALUE, rdat);
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped err", 1'b1, rerr);
        for (int lay = 0; lay < 2; lay++) begin
            step(24'h0, 14'h0);
            apb(1'b1, ADDR_CONTROL, lay);
            nl = lay[0];
            prev_acq = 1'b0;
            foreach (corner[i]) step(corner[i], 14'h3FFF);
            repeat (40) step(24'($random(seed)), 14'($random(seed)));
        end
        apb(1'b0, ADDR_FLAG_WORD, 32'h0);
        chk("flag copy", {8'h00, flag_word}, rdat);
        apb(1'b0, ADDR_DECODE_B, 32'h0);
        chk("decode b", {23'h0, 2'b00, flag_word[3:2], flag_word[8:6],
            flag_word[5:4]}, rdat);
        scan_done <= 1'b1;
        @(posedge pclk);
        scan_done <= 1'b0;
        repeat (2) @(posedge pclk);
        chk("scan idle", 1'b0, scan_busy);
        apb(1'b1, ADDR_CONTROL, 32'h2);
        @(negedge pclk);
        chk("sw start", 1'b1, program_start);
        @(negedge pclk);
        chk("sw pulse", 1'b0, program_start);
        @(posedge pclk);
        hw_start(2, 7, 1);
        apb(1'b1, ADDR_CONTROL, 32'h4);
        hw_start(8, 16, 1);
        apb(1'b1, ADDR_CONTROL, 32'h0);
        clear_req <= 1'b1;
        wait_clear(1'b1);
        hw_start(2, 7, 0);
        clear_req <= 1'b0;
        wait_clear(1'b0);
        close_out();
    end

    // Hang guard
    initial begin
        repeat (20000) @(posedge pclk);
        err_total++;
        close_out();
    end
endmodule : flag_word_pins_and_hardware_start_in_tb_top
